// File: rtl/ppm_port_mode.sv
// Port 1 low and port 2 high pin mode registers and decode
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`include "ppm_cfg.svh"
module ppm_port_mode #(
   parameter int PINS = `PPM_PINS
) (
   input wire logic sys_clk, // 125 MHz clock
   input wire logic srst, // Sync reset, active high
   input wire logic [7:0] reg_addr, // Register address
   input wire logic reg_bank, // Register bank select
   input wire logic [7:0] reg_wdata, // Write data
   input wire logic reg_wr, // Write strobe
   input wire logic reg_rd, // Read strobe
   output logic [7:0] reg_rdata_ff, // Read data, next cycle
   input wire logic [PINS-1:0] lcd_claim, // LCD control claims port 1 low pins
   output ppm_pkg::ppm_pad_s [PINS-1:0] p1_pad_ff, // Port 1 pins 0..3 pad controls
   output ppm_pkg::ppm_pad_s [PINS-1:0] p2_pad_ff // Port 2 pins 4..7 pad controls
);
   // Each register holds exactly four two-bit fields; no other width can map
   if (PINS != `PPM_PINS) begin : g_bad_pins
      $error("PINS must be four: each register holds four fields");
   end

   logic [7:0] p1_cfg_ff, nxt_p1_cfg;
   logic [7:0] p2_cfg_ff, nxt_p2_cfg;
   logic [7:0] nxt_rdata;
   logic [PINS-1:0] lcd_s1_ff, lcd_s2_ff;
   ppm_pkg::ppm_pad_s [PINS-1:0] p1_pad, p2_pad;
   logic hit_p1, hit_p2;

   // ==========================================================
   // Register access
   assign hit_p1 = (reg_bank == `PPM_BANK_SEL) && (reg_addr == `PPM_ADDR_P1_LOW);
   assign hit_p2 = (reg_bank == `PPM_BANK_SEL) && (reg_addr == `PPM_ADDR_P2_HIGH);

   // Next register values; unmapped reads give zero
   always_comb begin
      nxt_p1_cfg = p1_cfg_ff;
      nxt_p2_cfg = p2_cfg_ff;
      nxt_rdata = 8'h00;
      if (reg_wr && hit_p1) nxt_p1_cfg = reg_wdata;
      if (reg_wr && hit_p2) nxt_p2_cfg = reg_wdata;
      if (reg_rd && hit_p1) nxt_rdata = p1_cfg_ff;
      if (reg_rd && hit_p2) nxt_rdata = p2_cfg_ff;
   end

   // Registers clear to zero on reset
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         p1_cfg_ff <= `PPM_RST_P1_LOW;
         p2_cfg_ff <= `PPM_RST_P2_HIGH;
         reg_rdata_ff <= 8'h00;
      end else begin
         p1_cfg_ff <= nxt_p1_cfg;
         p2_cfg_ff <= nxt_p2_cfg;
         reg_rdata_ff <= nxt_rdata;
      end
   end

   // ==========================================================
   // LCD claim synchroniser; it comes from another block's pin logic
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         lcd_s1_ff <= '0;
         lcd_s2_ff <= '0;
      end else begin
         lcd_s1_ff <= lcd_claim;
         lcd_s2_ff <= lcd_s1_ff;
      end
   end

   // ==========================================================
   // Per-pin decode; field i sits at bits 2i+1:2i
   for (genvar i = 0; i < PINS; i++) begin : g_pin
      ppm_pin_decode #(.ALT_OK(1'b0)) u_p1 (
         .field(p1_cfg_ff[2*i+1:2*i]),
         .lcd_claim(lcd_s2_ff[i]),
         .pad(p1_pad[i]),
         .mode()
      );
      ppm_pin_decode #(.ALT_OK(1'b1)) u_p2 (
         .field(p2_cfg_ff[2*i+1:2*i]),
         .lcd_claim(1'b0),
         .pad(p2_pad[i]),
         .mode()
      );
   end

   // Pad outputs registered so the top drives only flops
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         p1_pad_ff <= '0;
         p2_pad_ff <= '0;
      end else begin
         p1_pad_ff <= p1_pad;
         p2_pad_ff <= p2_pad;
      end
   end
endmodule // ppm_port_mode

// File: rtl/ppm_cfg.svh
// Constants for the port pin mode select block
`ifndef PPM_CFG_SVH
`define PPM_CFG_SVH
// ==========================================================
// Register map (register bank 1)
`define PPM_BANK_SEL 1'b1
`define PPM_ADDR_P1_LOW 8'he5
`define PPM_ADDR_P2_HIGH 8'he6
`define PPM_RST_P1_LOW 8'h00
`define PPM_RST_P2_HIGH 8'h00
// ==========================================================
// Field encodings
`define PPM_FLD_INPUT 2'h0
`define PPM_FLD_PULLUP 2'h1
`define PPM_FLD_ALT 2'h2
`define PPM_FLD_OUTPUT 2'h3
`define PPM_FLD_W 2
`define PPM_PINS 4
`endif

// File: rtl/ppm_pkg.sv
// Types for the port pin mode select block
package ppm_pkg;
   // Resolved function of one pin
   typedef enum logic [2:0] {
      PPM_INPUT = 3'h0,
      PPM_PULLUP = 3'h1,
      PPM_OUTPUT = 3'h3,
      PPM_ALT = 3'h2,
      PPM_NONE = 3'h6
   } ppm_mode_e;
   // Pad controls of one pin
   typedef struct packed {
      logic pull_en;
      logic out_en;
      logic alt_en;
   } ppm_pad_s;
endpackage : ppm_pkg

// File: rtl/ppm_pin_decode.sv
// Decoder from a two-bit field to pad controls
`timescale 1ns/1ps
`include "ppm_cfg.svh"
module ppm_pin_decode #(
   parameter bit ALT_OK = 1'b0
) (
   input wire logic [1:0] field, // Two-bit config field
   input wire logic lcd_claim, // LCD function claims pin
   output ppm_pkg::ppm_pad_s pad, // Pad controls
   output ppm_pkg::ppm_mode_e mode // Resolved mode
);
   // Field decode; LCD claim overrides port drive
   always_comb begin
      pad = '0;
      mode = ppm_pkg::PPM_NONE;
      if (lcd_claim) begin
         pad.alt_en = 1'b1;
         mode = ppm_pkg::PPM_ALT;
      end else begin
         case (field)
            `PPM_FLD_INPUT: mode = ppm_pkg::PPM_INPUT;
            `PPM_FLD_PULLUP: begin
               pad.pull_en = 1'b1;
               mode = ppm_pkg::PPM_PULLUP;
            end
            `PPM_FLD_ALT: begin
               // Low port 1 pins: code selects no function
               pad.alt_en = ALT_OK;
               mode = ALT_OK ? ppm_pkg::PPM_ALT : ppm_pkg::PPM_NONE;
            end
            `PPM_FLD_OUTPUT: begin
               pad.out_en = 1'b1;
               mode = ppm_pkg::PPM_OUTPUT;
            end
            default: mode = ppm_pkg::PPM_NONE;
         endcase
      end
   end
endmodule // ppm_pin_decode

// File: tb/ppm_port_mode_asserts.sv
// Assertions for port pin mode select
`timescale 1ns/1ps
module ppm_port_mode_chk #(parameter int PINS = 4) (
   input logic sys_clk,
   input logic srst,
   input logic [7:0] reg_addr,
   input logic reg_bank,
   input logic [7:0] reg_wdata,
   input logic reg_wr,
   input logic reg_rd,
   input logic [7:0] reg_rdata_ff,
   input logic [PINS-1:0] lcd_claim,
   input ppm_pkg::ppm_pad_s [PINS-1:0] p1_pad_ff,
   input ppm_pkg::ppm_pad_s [PINS-1:0] p2_pad_ff
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   // ====
   // Hits; the idle cycle keeps a later write from masking pads
   wire h5 = reg_bank && reg_addr == 8'he5;
   wire h6 = reg_bank && reg_addr == 8'he6;
   wire w5 = reg_wr && h5;
   wire w6 = reg_wr && h6;
   rd_p1_a: assert property (w5 ##1 reg_rd && h5 |=> reg_rdata_ff == $past(reg_wdata, 2))
      else $error("p1 read");
   rd_p2_a: assert property (w6 ##1 reg_rd && h6 |=> reg_rdata_ff == $past(reg_wdata, 2))
      else $error("p2 read");
   // Read data stand only in the cycle after a mapped read
   rdata_idle_a: assert property (!(reg_rd && (h5 || h6)) |=> reg_rdata_ff == 8'h00)
      else $error("read data outside a read");
   alt_p2_a: assert property (w6 && reg_wdata[1:0] == 2'h2 ##1 !reg_wr |=> p2_pad_ff[0] == 3'h1)
      else $error("p2 alt");
   // A claim seen just before the write would override the field decode
   p1_mode_a: assert property (lcd_claim == '0 ##1 w5 && reg_wdata == 8'h6c ##1 !reg_wr
      |=> p1_pad_ff == 12'h810) else $error("p1 mode");
   claim_alt_a: assert property ($rose(lcd_claim[1]) ##1 lcd_claim[1] [*2] |=> p1_pad_ff[1].alt_en)
      else $error("claim");
   // Port 1 alt drive only ever comes from a claim seen three edges back
   for (genvar i = 0; i < PINS; i++) begin : g_pin
      p1_alt_claim_a: assert property (p1_pad_ff[i].alt_en |-> $past(lcd_claim[i], 3))
         else $error("p1 alt without claim");
   end
   // Main scenarios
   cover property (w5 ##1 reg_rd && h5);
   cover property (w6);
   cover property ($rose(lcd_claim[1]));
endmodule // ppm_port_mode_chk
bind ppm_port_mode ppm_port_mode_chk #(.PINS(PINS)) chk_inst (
   .sys_clk(sys_clk),
   .srst(srst),
   .reg_addr(reg_addr),
   .reg_bank(reg_bank),
   .reg_wdata(reg_wdata),
   .reg_wr(reg_wr),
   .reg_rd(reg_rd),
   .reg_rdata_ff(reg_rdata_ff),
   .lcd_claim(lcd_claim),
   .p1_pad_ff(p1_pad_ff),
   .p2_pad_ff(p2_pad_ff)
);

// File: tb/tb_ppm_port_mode.sv
// Testbench for port pin mode select
`timescale 1ns/1ps
module tb_ppm_port_mode;
   logic sys_clk = 0, srst = 1, reg_bank = 1, reg_wr = 0, reg_rd = 0;
   logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata_ff;
   logic [3:0] lcd_claim = 0;
   ppm_pkg::ppm_pad_s [3:0] p1_pad_ff, p2_pad_ff;
   int errors = 0, n_tests = 0;
   // Rows: address, data, read back, pads; e7 is unmapped, so port 2 pads stay
   logic [35:0] rows [5] = '{36'he5ffff492, 36'he56c6c810, 36'he6b4b42a0, 36'he68e8e211, 36'he75500211};
   ppm_port_mode ppm_port_mode_inst (
      .sys_clk(sys_clk),
      .srst(srst),
      .reg_addr(reg_addr),
      .reg_bank(reg_bank),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata_ff(reg_rdata_ff),
      .lcd_claim(lcd_claim),
      .p1_pad_ff(p1_pad_ff),
      .p2_pad_ff(p2_pad_ff)
   );
   initial forever #4 sys_clk = ~sys_clk;
   task automatic chk(logic [11:0] g, e);
      n_tests++;
      if (g !== e) begin
         errors++;
         $display("Error %0t got %h want %h", $time, g, e);
      end
   endtask
   // One strobe cycle from just after an edge; returns past the edge that takes it
   task automatic acc(logic [7:0] a, d, logic b, w);
      reg_addr <= a;
      reg_wdata <= d;
      reg_bank <= b;
      reg_wr <= w;
      reg_rd <= !w;
      @(posedge sys_clk);
      #1;
   endtask
   // Both strobes low for one cycle
   task automatic idle;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      @(posedge sys_clk);
      #1;
   endtask
   task automatic print_verdict;
      $display("checks %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // ====
   // Rows first, then refusal, claim and reset
   initial begin
      repeat (8) @(posedge sys_clk);
      srst <= 0;
      // Each write is followed at once by its read, with no gap
      foreach (rows[i]) begin
         acc(rows[i][35:28], rows[i][27:20], 1'b1, 1'b1);
         acc(rows[i][35:28], 8'h00, 1'b1, 1'b0);
         chk(reg_rdata_ff, rows[i][19:12]);
         chk(i < 2 ? p1_pad_ff : p2_pad_ff, rows[i][11:0]);
         $display("row %0d done", i);
      end
      // Bank 0 is refused for writes and reads
      acc(8'he5, 8'hff, 1'b0, 1'b1);
      acc(8'he5, 8'h00, 1'b1, 1'b0);
      chk(reg_rdata_ff, 8'h6c);
      acc(8'he5, 8'h00, 1'b0, 1'b0);
      chk(reg_rdata_ff, 8'h00);
      $display("bank test done");
      // Claim reaches the pad three edges after it is seen, not sooner
      lcd_claim <= 4'h2;
      idle;
      idle;
      chk(p1_pad_ff, 12'h810);
      idle;
      chk(p1_pad_ff, 12'h808);
      idle;
      $display("claim test done");
      // Mid-run reset clears both registers and the claim path
      srst <= 1'b1;
      lcd_claim <= 4'h0;
      idle;
      idle;
      srst <= 1'b0;
      acc(8'he5, 8'h00, 1'b1, 1'b0);
      chk(reg_rdata_ff, 8'h00);
      chk(p1_pad_ff, 12'h000);
      acc(8'he6, 8'h00, 1'b1, 1'b0);
      chk(reg_rdata_ff, 8'h00);
      chk(p2_pad_ff, 12'h000);
      idle;
      $display("reset test done");
      print_verdict();
   end
endmodule // tb_ppm_port_mode
